// [design/rcmr_defs.vh]
`ifndef RCMR_DEFS_VH
`define RCMR_DEFS_VH

// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
// printed offsets are not all multiples of four: byte address = 4 * index
`define RCMR_IDX_ON_D_LOW   8'hA2
`define RCMR_IDX_ON_D_HIGH  8'hA3
`define RCMR_IDX_EXT_CMD    8'hA4
`define RCMR_IDX_CHIP_MODE_CONTROL_ONE       8'hA5
`define RCMR_IDX_CTRL       8'hB0
`define RCMR_IDX_EVENT      8'hB1
`define RCMR_IDX_STATUS     8'hB2

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define RCMR_CMD_EOM        0
`define RCMR_CMD_TIMEOUT_STROBE      1
`define RCMR_CMD_FREQ       2
`define RCMR_CMD_GAIN       3
`define RCMR_CMC_XTAL       0
`define RCMR_CMC_LOCK       1
`define RCMR_CMC_FSCLR      2
`define RCMR_CMC_CYCLR      3
`define RCMR_CMC_EOMNCFG    4
`define RCMR_CMC_TOTNCH     5

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RCMR_RST_ON_LOW     8'h01
`define RCMR_RST_ON_HIGH    6'h00
`define RCMR_RST_CHIP_MODE_CONTROL_ONE       6'h04

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define RCMR_ON_FULL        15'h4000
`define RCMR_TUNIT_NS       1000
`define RCMR_CLK_NS         20

`endif

// [design/rcmr_ontime_timer.v]
`timescale 1ns/1ps
`include "rcmr_defs.vh"
// ----------------------------------------------------------------------
// on-time timer: counts base time units for the polling on-time
// ----------------------------------------------------------------------
module rcmr_ontime_timer #(
  parameter UNIT_CYCLES = `RCMR_TUNIT_NS / `RCMR_CLK_NS
) (
  input  wire        core_clk,
  input  wire        reset,
  input  wire        start,
  input  wire [13:0] setting,
  output reg         active_q,
  output reg         done_q
);
  reg [15:0] pre_q;
  reg [14:0] units_q;
  wire       tick;

  // one-cycle enable pulse at each base time unit
  assign tick = (pre_q == UNIT_CYCLES[15:0] - 16'h0001);

  // setting zero means the longest span, not zero time
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      pre_q    <= 16'h0000;
      units_q  <= 15'h0000;
      active_q <= 1'b0;
      done_q   <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start)
      begin
        pre_q    <= 16'h0000;
        units_q  <= (setting == 14'h0000) ? `RCMR_ON_FULL : {1'b0, setting}; // [RULE2] [RULE3]
        active_q <= 1'b1;
      end
      else if (active_q)
      begin
        pre_q <= tick ? 16'h0000 : pre_q + 16'h0001;
        if (tick)
        begin
          units_q <= units_q - 15'h0001;
          if (units_q == 15'h0001)
          begin
            active_q <= 1'b0;
            done_q   <= 1'b1;
          end
        end
      end
    end
  end
endmodule // rcmr_ontime_timer

// [design/rcmr_regs.v]
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "rcmr_defs.vh"
// Function
// (RULE1) on-time setting is high six bits joined above low eight bits
// (RULE2) on-time lasts setting times base time unit
// (RULE3) setting zero means 16384 base time units
// (RULE4) command bit 3 freezes gain control when source is host command
// (RULE5) command bit 2 freezes frequency control when source is host command
// (RULE6) command bit 1 forces timeout strobe only when selection is 1 or 2
// (RULE7) command bit 0 forces end-of-message strobe only when selection is 1 or 2
// (RULE8) bit 3 clears FIFO at operation start in slave run mode
// (RULE9) bit 3 clears FIFO at wakeup entering self-polling run mode
// (RULE10) bit 2 clears FIFO at each frame start, enabled after reset
// (RULE11) bit 1 locks FIFO at end of message
// (RULE12) locked FIFO also halts the receive chain until release
// (RULE13) bit 0 enables crystal precision in sleep, off after reset
// (RULE14) chip-mode register resets to 04, bits 7:6 read zero
// (RULE15) command bits are single-shot and clear themselves
module rcmr_regs #(
  parameter UNIT_CYCLES = `RCMR_TUNIT_NS / `RCMR_CLK_NS
) (
  input  wire        core_clk,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire        gain_freeze_source,
  input  wire        freq_freeze_source,
  input  wire [1:0]  external_processing_select,
  input  wire        slave_run_start,
  input  wire        wakeup_found,
  input  wire        frame_start,
  input  wire        message_end,
  input  wire        timeout_strobe,
  output reg         gain_manual_freeze_q,
  output reg         freq_manual_freeze_q,
  output reg         force_timeout_strobe_q,
  output reg         force_message_end_q,
  output reg         fifo_clear_q,
  output reg         fifo_locked_q,
  output reg         rx_chain_halt_q,
  output reg         crystal_precision_sleep_q,
  output reg  [5:0]  chip_mode_q,
  output reg         on_time_active_q,
  output reg         on_time_done_q
);
  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  function is_reg;
    input [11:0] a;
    input [7:0]  idx;
    begin
      is_reg = (a == {2'b00, idx, 2'b00});
    end
  endfunction

  function ext_mode;
    input [1:0] sel;
    begin
      ext_mode = (sel == 2'b01) || (sel == 2'b10);
    end
  endfunction

  reg  [7:0]  on_low_q;
  reg  [5:0]  on_high_q;
  reg  [5:0]  chip_mode_control_one_q;
  reg         lock_release_q;
  reg  [3:0]  cmd_q;
  wire        wr;
  wire        rd_ok;
  wire [13:0] on_time_d_setting;
  wire        tmr_active;
  wire        tmr_done;
  reg  [31:0] rdata_d;
  reg         hit_d;

  // one wait state; a write lands only at the edge where pready is seen high
  assign wr = psel && penable && pwrite && pready;
  assign rd_ok = psel && penable && !pwrite && !pready;
  assign on_time_d_setting = {on_high_q, on_low_q}; // [RULE1]

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  always @*
  begin
    hit_d   = 1'b1;
    rdata_d = 32'h0000_0000;
    if (is_reg(paddr, `RCMR_IDX_ON_D_LOW))
      rdata_d = {24'h000000, on_low_q};
    else if (is_reg(paddr, `RCMR_IDX_ON_D_HIGH))
      rdata_d = {26'h0000000, on_high_q};
    else if (is_reg(paddr, `RCMR_IDX_EXT_CMD))
      rdata_d = {28'h0000000, cmd_q};
    else if (is_reg(paddr, `RCMR_IDX_CHIP_MODE_CONTROL_ONE))
      rdata_d = {26'h0000000, chip_mode_control_one_q}; // [RULE14]
    else if (is_reg(paddr, `RCMR_IDX_CTRL) || is_reg(paddr, `RCMR_IDX_EVENT))
      rdata_d = 32'h0000_0000;
    else if (is_reg(paddr, `RCMR_IDX_STATUS))
      rdata_d = {29'h00000000, tmr_active, fifo_locked_q, rx_chain_halt_q};
    else
      hit_d = 1'b0;
  end

  // pready is a one-cycle pulse to end each access
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit_d;
      if (rd_ok)
        prdata <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      on_low_q  <= `RCMR_RST_ON_LOW;
      on_high_q <= `RCMR_RST_ON_HIGH;
      chip_mode_control_one_q    <= `RCMR_RST_CHIP_MODE_CONTROL_ONE; // [RULE10] [RULE13] [RULE14]
    end
    else if (wr)
    begin
      if (is_reg(paddr, `RCMR_IDX_ON_D_LOW))
        on_low_q <= pwdata[7:0];
      if (is_reg(paddr, `RCMR_IDX_ON_D_HIGH))
        on_high_q <= pwdata[5:0];
      if (is_reg(paddr, `RCMR_IDX_CHIP_MODE_CONTROL_ONE))
        chip_mode_control_one_q <= pwdata[5:0]; // bits 7:6 are dropped
    end
  end

  // ----------------------------------------------------------------------
  // single-shot commands
  // ----------------------------------------------------------------------
  // a command bit lives one cycle, then clears itself
  always @(posedge core_clk)
  begin
    if (reset)
      cmd_q <= 4'h0;
    else if (wr && is_reg(paddr, `RCMR_IDX_EXT_CMD))
      cmd_q <= pwdata[3:0];
    else
      cmd_q <= 4'h0; // [RULE15]
  end

  // gated command strobes and freeze levels; freeze holds until the
  // source is moved off host command, since the request is single-shot
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      gain_manual_freeze_q   <= 1'b0;
      freq_manual_freeze_q   <= 1'b0;
      force_timeout_strobe_q <= 1'b0;
      force_message_end_q    <= 1'b0;
    end
    else
    begin
      if (!gain_freeze_source)
        gain_manual_freeze_q <= 1'b0;
      else if (cmd_q[`RCMR_CMD_GAIN])
        gain_manual_freeze_q <= 1'b1; // [RULE4]
      if (!freq_freeze_source)
        freq_manual_freeze_q <= 1'b0;
      else if (cmd_q[`RCMR_CMD_FREQ])
        freq_manual_freeze_q <= 1'b1; // [RULE5]
      force_timeout_strobe_q <= cmd_q[`RCMR_CMD_TIMEOUT_STROBE]
        && ext_mode(external_processing_select); // [RULE6]
      force_message_end_q <= cmd_q[`RCMR_CMD_EOM]
        && ext_mode(external_processing_select); // [RULE7]
    end
  end

  // ----------------------------------------------------------------------
  // FIFO control
  // ----------------------------------------------------------------------
  wire eom_any;
  assign eom_any = message_end || (cmd_q[`RCMR_CMD_EOM] && ext_mode(external_processing_select));

  // a write with bit 0 set to the event register releases the FIFO lock
  always @(posedge core_clk)
  begin
    if (reset)
      lock_release_q <= 1'b0;
    else
      lock_release_q <= wr && is_reg(paddr, `RCMR_IDX_EVENT) && pwdata[0];
  end

  // lock wins over a release in the same cycle so no message end is lost
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      fifo_clear_q    <= 1'b0;
      fifo_locked_q   <= 1'b0;
      rx_chain_halt_q <= 1'b0;
    end
    else
    begin
      fifo_clear_q <= (chip_mode_control_one_q[`RCMR_CMC_CYCLR] && slave_run_start) // [RULE8]
        || (chip_mode_control_one_q[`RCMR_CMC_CYCLR] && wakeup_found)                // [RULE9]
        || (chip_mode_control_one_q[`RCMR_CMC_FSCLR] && frame_start);                // [RULE10]
      if (chip_mode_control_one_q[`RCMR_CMC_LOCK] && eom_any)
      begin
        fifo_locked_q   <= 1'b1; // [RULE11]
        rx_chain_halt_q <= 1'b1; // [RULE12]
      end
      else if (lock_release_q || !chip_mode_control_one_q[`RCMR_CMC_LOCK])
      begin
        fifo_locked_q   <= 1'b0;
        rx_chain_halt_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // mode outputs
  // ----------------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      crystal_precision_sleep_q <= 1'b0;
      chip_mode_q               <= `RCMR_RST_CHIP_MODE_CONTROL_ONE;
      on_time_active_q          <= 1'b0;
      on_time_done_q            <= 1'b0;
    end
    else
    begin
      crystal_precision_sleep_q <= chip_mode_control_one_q[`RCMR_CMC_XTAL]; // [RULE13]
      chip_mode_q               <= chip_mode_control_one_q;
      on_time_active_q          <= tmr_active;
      on_time_done_q            <= tmr_done;
    end
  end

  // on-time timer starts on a write with bit 0 set to the control register
  rcmr_ontime_timer #(
    .UNIT_CYCLES (UNIT_CYCLES)
  ) u_timer (
    .core_clk (core_clk),
    .reset    (reset),
    .start    (wr && is_reg(paddr, `RCMR_IDX_CTRL) && pwdata[0]),
    .setting  (on_time_d_setting),
    .active_q (tmr_active),
    .done_q   (tmr_done)
  );
endmodule // rcmr_regs

// [test/rcmr_regs_sva.sv]
`timescale 1ns/1ps
// watches the event-driven outputs of the register bank
module rcmr_regs_sva (
  input wire       core_clk,
  input wire       reset,
  input wire [1:0] external_processing_select,
  input wire       slave_run_start,
  input wire       wakeup_found,
  input wire       frame_start,
  input wire       message_end,
  input wire       force_message_end_q,
  input wire       fifo_clear_q,
  input wire       fifo_locked_q,
  input wire       rx_chain_halt_q,
  input wire       crystal_precision_sleep_q,
  input wire [5:0] chip_mode_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_eom_sel; force_message_end_q |-> external_processing_select inside {2'h1, 2'h2}; endproperty
  a_eom_sel: assert property (p_eom_sel) else $error("strobe outside ext mode");
  property p_eom_one; force_message_end_q |=> !force_message_end_q; endproperty
  a_eom_one: assert property (p_eom_one) else $error("strobe too long");
  property p_fs; frame_start && chip_mode_q[2] |=> fifo_clear_q; endproperty
  a_fs: assert property (p_fs) else $error("no frame clear");
  property p_cy; (slave_run_start || wakeup_found) && chip_mode_q[3] |=> fifo_clear_q; endproperty
  a_cy: assert property (p_cy) else $error("no cycle clear");
  // a clear with no enabled cause means a mask was ignored
  property p_why; fifo_clear_q |-> $past(frame_start && chip_mode_q[2] ||
    (slave_run_start || wakeup_found) && chip_mode_q[3]); endproperty
  a_why: assert property (p_why) else $error("clear without cause");
  property p_lk; message_end && chip_mode_q[1] |=> fifo_locked_q; endproperty
  a_lk: assert property (p_lk) else $error("no lock");
  property p_hlt; $rose(fifo_locked_q) |-> ##[0:1] rx_chain_halt_q; endproperty
  a_hlt: assert property (p_hlt) else $error("no halt");
  property p_xt; crystal_precision_sleep_q == chip_mode_q[0]; endproperty
  a_xt: assert property (p_xt) else $error("precision bit");
  property p_rst; disable iff (1'h0) reset |=> chip_mode_q == 6'h04; endproperty
  a_rst: assert property (p_rst) else $error("mode reset value");
endmodule // rcmr_regs_sva
bind rcmr_regs rcmr_regs_sva i_sva (.core_clk(core_clk), .reset(reset),
  .external_processing_select(external_processing_select), .message_end(message_end),
  .slave_run_start(slave_run_start), .wakeup_found(wakeup_found), .frame_start(frame_start),
  .force_message_end_q(force_message_end_q), .fifo_clear_q(fifo_clear_q),
  .fifo_locked_q(fifo_locked_q), .rx_chain_halt_q(rx_chain_halt_q),
  .crystal_precision_sleep_q(crystal_precision_sleep_q), .chip_mode_q(chip_mode_q));

// [test/test_rcmr_regs.sv]
`timescale 1ns/1ps
`include "rcmr_defs.vh"
module test_rcmr_regs;
  reg          core_clk, reset, psel, penable, pwrite, gsrc, fsrc;
  reg  [1:0]   esel;
  reg  [3:0]   evt;
  reg  [11:0]  paddr;
  reg  [31:0]  pwdata, seed;
  wire         pready, pslverr, gfz, ffz, fto, feom, fclr, flk, halt, act, xtal, tdone;
  wire [31:0]  prdata;
  wire [5:0]   cm;
  integer      err_total, total_checks, cyc, n_eom, n_to, n_clr, len, s;
  logic [33:0] e;
  logic [33:0] rsp_q[$];
  integer      dur_q[$];
  rcmr_regs #(.UNIT_CYCLES(2)) i_dut (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .gain_freeze_source(gsrc), .freq_freeze_source(fsrc),
    .external_processing_select(esel), .slave_run_start(evt[1]), .wakeup_found(evt[2]),
    .frame_start(evt[0]), .message_end(evt[3]), .timeout_strobe(1'h0),
    .gain_manual_freeze_q(gfz), .freq_manual_freeze_q(ffz), .force_timeout_strobe_q(fto),
    .force_message_end_q(feom), .fifo_clear_q(fclr), .fifo_locked_q(flk),
    .rx_chain_halt_q(halt), .crystal_precision_sleep_q(xtal), .chip_mode_q(cm),
    .on_time_active_q(act), .on_time_done_q(tdone));
  // free-running core clock
  initial
  begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end
  function logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'h1)
    begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // the answer is noted before the request leaves; the wait is open-ended by design
  task xfer(input logic w, input logic [7:0] i, input logic [31:0] d, input logic er);
    rsp_q.push_back({~w, er, w ? 32'h0 : d});
    @(posedge core_clk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= {2'h0, i, 2'h0};
    pwdata <= w ? d : 32'h0;
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task pulse(input logic [3:0] v);
    @(posedge core_clk);
    evt <= v;
    @(posedge core_clk);
    evt <= 4'h0;
  endtask
  task ontime(input logic [5:0] hi, input logic [7:0] lo, input integer n);
    xfer(1'h1, `RCMR_IDX_ON_D_HIGH, {26'h0, hi}, 1'h0);
    xfer(1'h1, `RCMR_IDX_ON_D_LOW, {24'h0, lo}, 1'h0);
    dur_q.push_back(n);
    xfer(1'h1, `RCMR_IDX_CTRL, 32'h1, 1'h0);
    while (dur_q.size() != 0) @(posedge core_clk);
    xfer(1'h1, `RCMR_IDX_CTRL, 32'h0, 1'h0);
  endtask
  // output watcher: pops the oldest note whenever an answer or a timer run ends
  always @(posedge core_clk)
  begin
    cyc   <= cyc + 1;
    n_eom <= n_eom + (feom === 1'h1);
    n_to  <= n_to + (fto === 1'h1);
    n_clr <= n_clr + (fclr === 1'h1);
    if (act === 1'h1)
      len <= len + 1;
    else if (len != 0)
    begin
      chk(dur_q.size() != 0 && tdone === 1'h1 && len == dur_q.pop_front(), "on-time");
      len <= 0;
    end
    if (pready === 1'h1 && reset === 1'h0)
    begin
      e = rsp_q.pop_front();
      chk(pslverr === e[32] && (!e[33] || prdata === e[31:0]), "apb answer");
    end
    if (cyc == 60000)
    begin
      err_total++;
      wrap_up;
    end
  end
  // main sequence
  initial
  begin
    {psel, penable, pwrite, gsrc, fsrc, esel, evt, paddr, pwdata} = 0;
    {err_total, total_checks, cyc, n_eom, n_to, n_clr, len} = 0;
    seed  = 32'h72880ED4;
    reset = 1'h1;
    repeat (20) @(posedge core_clk);
    reset <= 1'h0;
    xfer(1'h0, `RCMR_IDX_CHIP_MODE_CONTROL_ONE, 32'h04, 1'h0);
    xfer(1'h0, `RCMR_IDX_ON_D_HIGH, 32'h0, 1'h0);
    pulse(4'h1);
    repeat (2) @(posedge core_clk);
    chk(n_clr == 1, "frame clear");
    xfer(1'h1, `RCMR_IDX_CHIP_MODE_CONTROL_ONE, 32'hFF, 1'h0);
    xfer(1'h0, `RCMR_IDX_CHIP_MODE_CONTROL_ONE, 32'h3F, 1'h0);
    chk(xtal === 1'h1, "precision on");
    xfer(1'h0, 8'h00, 32'h0, 1'h1);
    xfer(1'h1, 8'h00, 32'hFFFFFFFF, 1'h1);
    pulse(4'h2);
    pulse(4'h4);
    pulse(4'h1);
    repeat (2) @(posedge core_clk);
    chk(n_clr == 4, "cycle clears");
    pulse(4'h8);
    repeat (2) @(posedge core_clk);
    chk(flk === 1'h1 && halt === 1'h1, "lock");
    xfer(1'h1, `RCMR_IDX_EVENT, 32'h1, 1'h0);
    repeat (3) @(posedge core_clk);
    chk(flk === 1'h0 && halt === 1'h0, "release");
    xfer(1'h1, `RCMR_IDX_CHIP_MODE_CONTROL_ONE, 32'h0, 1'h0);
    pulse(4'h7);
    repeat (2) @(posedge core_clk);
    chk(n_clr == 4, "clears off");
    chk(xtal === 1'h0, "precision off");
    gsrc <= 1'h1;
    fsrc <= 1'h1;
    for (s = 0; s < 4; s++)
    begin
      esel <= s[1:0];
      seed = xs(seed);
      xfer(1'h1, `RCMR_IDX_EXT_CMD, {seed[31:4], 4'hF}, 1'h0);
      repeat (4) @(posedge core_clk);
    end
    chk(n_eom == 2 && n_to == 2, "forced strobes");
    chk(gfz === 1'h1 && ffz === 1'h1, "freeze");
    xfer(1'h0, `RCMR_IDX_EXT_CMD, 32'h0, 1'h0);
    gsrc <= 1'h0;
    fsrc <= 1'h0;
    xfer(1'h1, `RCMR_IDX_EXT_CMD, 32'hC, 1'h0);
    repeat (4) @(posedge core_clk);
    chk(gfz === 1'h0 && ffz === 1'h0, "no freeze");
    seed = xs(seed);
    ontime(6'h00, 8'h01, 2);
    ontime(6'h01, seed[7:0], (256 + seed[7:0]) * 2);
    ontime(6'h00, 8'h00, 32768);
    wrap_up;
  end
endmodule // test_rcmr_regs
